/* File: vrdvfp_top.sv */
// reference ramping, protection masking and fault handling for two regulator sections
`timescale 1ns/1ps
`default_nettype none

module vrdvfp_top #(
    parameter int MASK_DELAY_CYCLES = vrdvfp_pkg::MASK_DELAY_DEFAULT,
    parameter int MAIN_PHASES       = 4
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_sys_rst,
    input  wire logic                        i_enable,
    input  wire logic                        i_cmd_valid,
    input  wire logic                        i_cmd_main,
    input  wire logic                        i_cmd_aux,
    input  wire logic [vrdvfp_pkg::MV_W-1:0] i_cmd_target,
    input  wire logic                        i_voltage_set_fast_cmd,
    input  wire logic                        i_power_state_cmd,
    input  wire logic [7:0]                  i_power_state,
    input  wire logic [2:0]                  i_phase_count,
    input  wire logic [vrdvfp_pkg::MV_W-1:0] i_main_output_sense,
    input  wire logic [vrdvfp_pkg::MV_W-1:0] i_aux_output_sense,
    input  wire logic [vrdvfp_pkg::MV_W-1:0] i_total_current_monitor,
    input  wire logic [MAIN_PHASES-1:0]      i_main_info_over,
    input  wire logic                        i_aux_info_over,
    output logic      [vrdvfp_pkg::MV_W-1:0] o_main_ref,
    output logic      [vrdvfp_pkg::MV_W-1:0] o_aux_ref,
    output logic      [MAIN_PHASES-1:0]      o_main_phase_drive_outputs,
    output logic      [MAIN_PHASES-1:0]      o_main_low_side_switch,
    output logic                             o_aux_phase_drive_outputs,
    output logic                             o_aux_low_side_switch,
    output logic                             o_main_driver_enable,
    output logic                             o_aux_driver_enable,
    output logic                             o_fault_indication_pin,
    output logic                             o_fault_latched,
    output logic      [1:0]                  o_ramping,
    output logic      [1:0]                  o_protect_masked,
    output logic      [vrdvfp_pkg::MV_W-1:0] o_oc_level
);
    localparam int MW = vrdvfp_pkg::MV_W;
    localparam int SW = vrdvfp_pkg::STEP_W;

    initial begin
        if (MASK_DELAY_CYCLES < 1 || MASK_DELAY_CYCLES > 1048575) begin
            $error("MASK_DELAY_CYCLES out of range");
        end
        if (MAIN_PHASES != 4) begin
            $error("MAIN_PHASES must be 4");
        end
        if (vrdvfp_pkg::FAST_STEP_CYCLES < 1 || vrdvfp_pkg::FAST_STEP_CYCLES > 2 ** SW) begin
            $error("fast step period does not fit the step counter");
        end
        if (vrdvfp_pkg::SLOW_STEP_CYCLES < 1 || vrdvfp_pkg::SLOW_STEP_CYCLES > 2 ** SW) begin
            $error("slow step period does not fit the step counter");
        end
    end

    vrdvfp_pkg::vrdvfp_fault_t fault;
    vrdvfp_pkg::vrdvfp_fault_t next_fault;

    logic [MW-1:0] sense [2];
    logic [MW-1:0] ref_v [2];
    logic [1:0]    cmd_sel;
    logic [1:0]    ov_hit;
    logic [1:0]    uv_hit;
    logic [1:0]    masked;
    logic          low_ps;
    logic          oc_hit;
    logic [2:0]    cfg_n;
    logic [2:0]    run_n;

    assign sense[0] = i_main_output_sense;
    assign sense[1] = i_aux_output_sense;
    assign cmd_sel  = {i_cmd_aux, i_cmd_main};

    // per-section reference ramp and protection masking
    for (genvar g = 0; g < 2; g++) begin : g_sect
        logic [MW-1:0] tgt;
        logic          fast;
        logic [SW-1:0] step_cnt;
        logic [19:0]   mask_cnt;
        logic          ramping;
        logic          ov_ramp;
        logic [MW:0]   ov_lim;
        logic [MW:0]   uv_sum;

        assign ramping = ref_v[g] != tgt;
        assign ov_ramp = (g == 0) ? (fault == vrdvfp_pkg::FAULT_OV_MAIN)
                                  : (fault == vrdvfp_pkg::FAULT_OV_AUX);
        assign ov_lim  = {1'b0, ref_v[g]} + {1'b0, vrdvfp_pkg::OV_ABOVE_MV};
        assign uv_sum  = {1'b0, sense[g]} + {1'b0, vrdvfp_pkg::UV_BELOW_MV};

        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                tgt  <= vrdvfp_pkg::REF_RESET_MV;
                fast <= 1'b0;
            end else if (!i_enable) begin
                tgt  <= vrdvfp_pkg::REF_RESET_MV;
                fast <= 1'b0;
            end else if (ov_ramp) begin
                tgt  <= vrdvfp_pkg::OV_FLOOR_MV;
                fast <= 1'b1;
            end else if (fault == vrdvfp_pkg::FAULT_NONE && i_cmd_valid && cmd_sel[g]) begin
                tgt  <= i_cmd_target;
                fast <= i_voltage_set_fast_cmd;
            end
        end

        // one 1 mV step per period; period sets the slope
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                ref_v[g] <= vrdvfp_pkg::REF_RESET_MV;
                step_cnt <= '0;
            end else if (!i_enable) begin
                ref_v[g] <= vrdvfp_pkg::REF_RESET_MV;
                step_cnt <= '0;
            end else if (!ramping || !(fault == vrdvfp_pkg::FAULT_NONE || ov_ramp)) begin
                step_cnt <= '0;
            end else if (step_cnt != '0) begin
                step_cnt <= step_cnt - 1'b1;
            end else begin
                // step first, then wait, so the first 1 mV lands one edge after the command
                step_cnt <= fast ? SW'(vrdvfp_pkg::FAST_STEP_CYCLES - 1)
                                 : SW'(vrdvfp_pkg::SLOW_STEP_CYCLES - 1);
                if (tgt > ref_v[g]) begin
                    ref_v[g] <= ref_v[g] + 1'b1;
                end else begin
                    ref_v[g] <= ref_v[g] - 1'b1;
                end
            end
        end

        // mask holds for the ramp and a fixed count after it
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                mask_cnt  <= '0;
                masked[g] <= 1'b0;
            end else if (!i_enable) begin
                // enable low drops the reference, so no tail is left to guard
                mask_cnt  <= '0;
                masked[g] <= 1'b0;
            end else if (ramping) begin
                mask_cnt  <= 20'(MASK_DELAY_CYCLES);
                masked[g] <= 1'b1;
            end else begin
                if (mask_cnt != '0) begin
                    mask_cnt <= mask_cnt - 1'b1;
                end
                masked[g] <= mask_cnt > 20'h00001;
            end
        end

        always_comb begin
            ov_hit[g] = !masked[g] && !ramping && {1'b0, sense[g]} >= ov_lim;
            uv_hit[g] = !masked[g] && !ramping && ref_v[g] > vrdvfp_pkg::UV_ARM_REF_MV
                        && uv_sum <= {1'b0, ref_v[g]};
        end
    end

    // power state selects phase limit and total overcurrent level
    // the state code survives enable cycling; only reset or a full-power state command returns it to full power
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            low_ps <= 1'b0;
        end else if (i_power_state_cmd) begin
            low_ps <= i_power_state != vrdvfp_pkg::FULL_POWER_STATE;
        end
    end

    always_comb begin
        // out-of-range strap values fall back to the nearest legal count
        if (i_phase_count < vrdvfp_pkg::MIN_PHASES) begin
            cfg_n = vrdvfp_pkg::MIN_PHASES;
        end else if (i_phase_count > vrdvfp_pkg::MAX_PHASES) begin
            cfg_n = vrdvfp_pkg::MAX_PHASES;
        end else begin
            cfg_n = i_phase_count;
        end
        run_n = (low_ps && cfg_n > vrdvfp_pkg::LOW_PS_MAX_PHASES)
              ? vrdvfp_pkg::LOW_PS_MAX_PHASES : cfg_n;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_oc_level <= vrdvfp_pkg::OC_TOT_MV;
        // two phases keep the full level; only wider setups are scaled down
        end else if (low_ps && cfg_n == 3'h4) begin
            o_oc_level <= vrdvfp_pkg::OC_LOW_N4_MV;
        end else if (low_ps && cfg_n == 3'h3) begin
            o_oc_level <= vrdvfp_pkg::OC_LOW_N3_MV;
        end else begin
            o_oc_level <= vrdvfp_pkg::OC_TOT_MV;
        end
    end

    // never masked, so it also catches ramps
    assign oc_hit = i_total_current_monitor >= o_oc_level;

    // fault latch: once set, nothing but enable low leaves it
    always_comb begin
        next_fault = fault;
        if (fault == vrdvfp_pkg::FAULT_NONE) begin
            // total overcurrent first: it is the one fault a ramp cannot hide
            if (oc_hit) begin
                next_fault = vrdvfp_pkg::FAULT_SHUTDOWN;
            end else if (ov_hit[0]) begin
                next_fault = vrdvfp_pkg::FAULT_OV_MAIN;
            end else if (ov_hit[1]) begin
                next_fault = vrdvfp_pkg::FAULT_OV_AUX;
            end else if (uv_hit != 2'b00) begin
                next_fault = vrdvfp_pkg::FAULT_SHUTDOWN;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fault <= vrdvfp_pkg::FAULT_NONE;
        end else if (!i_enable) begin
            fault <= vrdvfp_pkg::FAULT_NONE;
        end else begin
            fault <= next_fault;
        end
    end

    // main section phase drive
    for (genvar p = 0; p < MAIN_PHASES; p++) begin : g_phase
        always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
                o_main_phase_drive_outputs[p] <= 1'b0;
                o_main_low_side_switch[p]     <= 1'b0;
            end else if (!i_enable || 3'(p) >= run_n) begin
                o_main_phase_drive_outputs[p] <= 1'b0;
                o_main_low_side_switch[p]     <= 1'b0;
            end else begin
                case (fault)
                    vrdvfp_pkg::FAULT_NONE: begin
                        o_main_phase_drive_outputs[p] <= !i_main_info_over[p];
                        o_main_low_side_switch[p]     <= i_main_info_over[p];
                    end
                    // low side pulls down only while the output sits above the falling reference
                    vrdvfp_pkg::FAULT_OV_MAIN: begin
                        o_main_phase_drive_outputs[p] <= 1'b0;
                        o_main_low_side_switch[p]     <= i_main_output_sense >= vrdvfp_pkg::OV_FLOOR_MV
                                                         && i_main_output_sense > ref_v[0];
                    end
                    default: begin
                        o_main_phase_drive_outputs[p] <= 1'b0;
                        o_main_low_side_switch[p]     <= 1'b0;
                    end
                endcase
            end
        end
    end

    // aux section phase drive
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_aux_phase_drive_outputs <= 1'b0;
            o_aux_low_side_switch     <= 1'b0;
        end else if (!i_enable) begin
            o_aux_phase_drive_outputs <= 1'b0;
            o_aux_low_side_switch     <= 1'b0;
        end else begin
            case (fault)
                vrdvfp_pkg::FAULT_NONE: begin
                    o_aux_phase_drive_outputs <= !i_aux_info_over;
                    o_aux_low_side_switch     <= i_aux_info_over;
                end
                // same pull-down pacing as the main section
                vrdvfp_pkg::FAULT_OV_AUX: begin
                    o_aux_phase_drive_outputs <= 1'b0;
                    o_aux_low_side_switch     <= i_aux_output_sense >= vrdvfp_pkg::OV_FLOOR_MV
                                                 && i_aux_output_sense > ref_v[1];
                end
                default: begin
                    o_aux_phase_drive_outputs <= 1'b0;
                    o_aux_low_side_switch     <= 1'b0;
                end
            endcase
        end
    end

    // driver enables, fault pin and status
    // enable gates every bit so a cleared fault shows at the same edge
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_main_driver_enable   <= 1'b0;
            o_aux_driver_enable    <= 1'b0;
            o_fault_indication_pin <= 1'b0;
            o_fault_latched        <= 1'b0;
        end else begin
            o_main_driver_enable   <= i_enable && (fault == vrdvfp_pkg::FAULT_NONE
                                      || fault == vrdvfp_pkg::FAULT_OV_MAIN);
            o_aux_driver_enable    <= i_enable && (fault == vrdvfp_pkg::FAULT_NONE
                                      || fault == vrdvfp_pkg::FAULT_OV_AUX);
            o_fault_indication_pin <= i_enable && (fault == vrdvfp_pkg::FAULT_OV_MAIN
                                      || fault == vrdvfp_pkg::FAULT_OV_AUX);
            o_fault_latched        <= i_enable && fault != vrdvfp_pkg::FAULT_NONE;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_main_ref       <= vrdvfp_pkg::REF_RESET_MV;
            o_aux_ref        <= vrdvfp_pkg::REF_RESET_MV;
            o_ramping        <= 2'b00;
            o_protect_masked <= 2'b00;
        end else begin
            o_main_ref       <= ref_v[0];
            o_aux_ref        <= ref_v[1];
            o_ramping        <= {g_sect[1].ramping, g_sect[0].ramping};
            // mask register lags the ramp by one edge; or-ing the ramp keeps the flag honest
            o_protect_masked <= masked | {g_sect[1].ramping, g_sect[0].ramping};
        end
    end

endmodule // vrdvfp_top

`default_nettype wire

/* File: vrdvfp_pkg.sv */
// constants and types shared by the reference ramp and fault protection block
package vrdvfp_pkg;
    localparam int CLK_MHZ             = 200;
    localparam int FAST_SLEW_MV_PER_US = 20;
    localparam int SLOW_SLEW_MV_PER_US = 5;
    // cycles per 1 mV reference step
    localparam int FAST_STEP_CYCLES    = CLK_MHZ / FAST_SLEW_MV_PER_US;
    localparam int SLOW_STEP_CYCLES    = CLK_MHZ / SLOW_SLEW_MV_PER_US;
    localparam int MV_W                = 12;
    localparam int STEP_W              = 8;
    localparam logic [11:0] OV_ABOVE_MV   = 12'h0AF;
    localparam logic [11:0] OV_FLOOR_MV   = 12'h0FA;
    localparam logic [11:0] UV_BELOW_MV   = 12'h1F4;
    localparam logic [11:0] UV_ARM_REF_MV = 12'h1F4;
    localparam logic [11:0] OC_TOT_MV     = 12'h60E;
    localparam logic [11:0] OC_LOW_N3_MV  = 12'h41A;
    localparam logic [11:0] OC_LOW_N4_MV  = 12'h320;
    localparam logic [2:0]  LOW_PS_MAX_PHASES = 3'h2;
    localparam logic [2:0]  MIN_PHASES        = 3'h2;
    localparam logic [2:0]  MAX_PHASES        = 3'h4;
    localparam logic [7:0]  FULL_POWER_STATE  = 8'h00;
    localparam logic [11:0] REF_RESET_MV      = 12'h000;
    localparam int          MASK_DELAY_DEFAULT = 1000;

    typedef enum logic [1:0] {
        FAULT_NONE     = 2'b00,
        FAULT_OV_MAIN  = 2'b01,
        FAULT_OV_AUX   = 2'b10,
        FAULT_SHUTDOWN = 2'b11
    } vrdvfp_fault_t;
endpackage

/* File: vrdvfp_sva.sv */
// concurrent checks on the ports of the ramp and protection block
`timescale 1ns/1ps
`default_nettype none
module vrdvfp_sva #(
    parameter int MASK_DELAY_CYCLES = 8,
    parameter int MAIN_PHASES       = 4
) (
    input wire logic                   i_clk,
    input wire logic                   i_sys_rst,
    input wire logic                   i_enable,
    input wire logic                   i_cmd_valid,
    input wire logic                   i_power_state_cmd,
    input wire logic [7:0]             i_power_state,
    input wire logic [11:0]            i_main_output_sense,
    input wire logic [11:0]            i_total_current_monitor,
    input wire logic [MAIN_PHASES-1:0] i_main_info_over,
    input wire logic [11:0]            o_main_ref,
    input wire logic [MAIN_PHASES-1:0] o_main_phase_drive_outputs,
    input wire logic [MAIN_PHASES-1:0] o_main_low_side_switch,
    input wire logic                   o_aux_phase_drive_outputs,
    input wire logic                   o_aux_low_side_switch,
    input wire logic                   o_main_driver_enable,
    input wire logic                   o_aux_driver_enable,
    input wire logic                   o_fault_indication_pin,
    input wire logic                   o_fault_latched,
    input wire logic [1:0]             o_ramping,
    input wire logic [1:0]             o_protect_masked,
    input wire logic [11:0]            o_oc_level
);
    localparam int MASK_WAIT = MASK_DELAY_CYCLES + 32;
    logic [3:0] en_run;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    // settle time after enable returns, so clearing effects are not misread
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            en_run <= 4'h0;
        end else if (!i_enable) begin
            en_run <= 4'h0;
        end else if (en_run != 4'hF) begin
            en_run <= en_run + 4'h1;
        end
    end
    wire logic live = en_run == 4'hF && !o_fault_latched;
    oc_latch_a: assert property (live && i_total_current_monitor >= o_oc_level |-> ##[1:3] o_fault_latched)
        else $error("total overcurrent did not latch");
    ov_main_a: assert property (live && !i_cmd_valid && o_ramping == 2'b00 && !o_protect_masked[0]
        && i_total_current_monitor < o_oc_level && {1'b0, i_main_output_sense} >= {1'b0, o_main_ref} + 13'h0AF
        |-> ##[1:3] o_fault_indication_pin) else $error("overvoltage pin not raised");
    latch_hold_a: assert property ((o_fault_latched && i_enable) ##1 i_enable |=> o_fault_latched)
        else $error("latched fault dropped with enable high");
    ov_split_a: assert property (o_fault_indication_pin |-> (o_main_driver_enable ^ o_aux_driver_enable)
        && (o_aux_driver_enable || !o_aux_phase_drive_outputs && !o_aux_low_side_switch))
        else $error("overvoltage section split wrong");
    ov_drive_a: assert property (o_fault_indication_pin && o_main_driver_enable |-> o_main_phase_drive_outputs == '0)
        else $error("faulting section still switching");
    shut_off_a: assert property (o_fault_latched ##1 (o_fault_latched && !o_fault_indication_pin)
        |-> !o_main_driver_enable && !o_aux_driver_enable && o_main_low_side_switch == '0)
        else $error("shutdown left a driver on");
    ls_force_a: assert property ((live && i_main_info_over[0]) ##1 !o_fault_latched
        |-> o_main_low_side_switch[0] && !o_main_phase_drive_outputs[0])
        else $error("phase limit did not force low side");
    ps_limit_a: assert property (live && i_power_state_cmd && i_power_state != 8'h00
        |-> ##3 $countones(o_main_phase_drive_outputs | o_main_low_side_switch) <= 2)
        else $error("too many phases in reduced state");
    mask_ramp_a: assert property (live && o_ramping[0] |-> o_protect_masked[0])
        else $error("protection open during ramp");
    mask_tail_a: assert property (live && $fell(o_ramping[0])
        |-> o_protect_masked[0] [*4] ##[1:MASK_WAIT] !o_protect_masked[0])
        else $error("mask tail wrong");
    ov_seen_c: cover property ($rose(o_fault_indication_pin));
    shut_seen_c: cover property (o_fault_latched && !o_fault_indication_pin);
    ramp_seen_c: cover property ($fell(o_ramping[0]));
endmodule // vrdvfp_sva
bind vrdvfp_top vrdvfp_sva #(.MASK_DELAY_CYCLES(MASK_DELAY_CYCLES), .MAIN_PHASES(MAIN_PHASES)) u_sva (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_enable(i_enable), .i_cmd_valid(i_cmd_valid),
    .i_power_state_cmd(i_power_state_cmd), .i_power_state(i_power_state),
    .i_main_output_sense(i_main_output_sense), .i_total_current_monitor(i_total_current_monitor),
    .i_main_info_over(i_main_info_over), .o_main_ref(o_main_ref),
    .o_main_phase_drive_outputs(o_main_phase_drive_outputs), .o_main_low_side_switch(o_main_low_side_switch),
    .o_aux_phase_drive_outputs(o_aux_phase_drive_outputs), .o_aux_low_side_switch(o_aux_low_side_switch),
    .o_main_driver_enable(o_main_driver_enable), .o_aux_driver_enable(o_aux_driver_enable),
    .o_fault_indication_pin(o_fault_indication_pin), .o_fault_latched(o_fault_latched),
    .o_ramping(o_ramping), .o_protect_masked(o_protect_masked), .o_oc_level(o_oc_level));
`default_nettype wire

/* File: vrdvfp_vid_master.sv */
// serial voltage command master model feeding the regulator block
`timescale 1ns/1ps
`default_nettype none
module vrdvfp_vid_master (
    input  wire logic        i_clk,
    input  wire logic        i_send,
    input  wire logic        i_main,
    input  wire logic        i_aux,
    input  wire logic        i_fast,
    input  wire logic [11:0] i_target,
    input  wire logic        i_ps_send,
    input  wire logic [7:0]  i_ps,
    output logic             o_cmd_valid,
    output logic             o_cmd_main,
    output logic             o_cmd_aux,
    output logic             o_fast,
    output logic [11:0]      o_target,
    output logic             o_ps_cmd,
    output logic [7:0]       o_ps
);
    initial begin
        {o_cmd_valid, o_cmd_main, o_cmd_aux, o_fast, o_target, o_ps_cmd, o_ps} = '0;
    end
    // fields mean nothing without the strobe, so idle cycles show flipped bits
    always @(posedge i_clk) begin
        o_cmd_valid <= i_send;
        o_ps_cmd    <= i_ps_send;
        o_cmd_main  <= i_send ? i_main : ~o_cmd_main;
        o_cmd_aux   <= i_send ? i_aux : ~o_cmd_aux;
        o_fast      <= i_send ? i_fast : ~o_fast;
        o_target    <= i_send ? i_target : ~o_target;
        o_ps        <= i_ps_send ? i_ps : ~o_ps;
    end
endmodule // vrdvfp_vid_master
`default_nettype wire

/* File: vrdvfp_test.sv */
// self-checking bench for the ramp and protection block
`timescale 1ns/1ps
`default_nettype none
module vrdvfp_test;
    localparam int MD = 8;
    typedef struct {logic m; logic a; logic f; logic [11:0] t; int cyc; logic [11:0] oth;} vrdvfp_row_t;
    logic        clk = 1'b0, rst = 1'b1, en = 1'b1, snd = 1'b0, sm = 1'b0, sa = 1'b0, sf = 1'b0, pss = 1'b0;
    logic [11:0] tgt = 12'h000, msen = 12'h000, total_current_monitor = 12'h000, mref, aref, oc, ct;
    logic [7:0]  ps = 8'h00, pso;
    logic [3:0]  info = 4'h0, drv, ls;
    logic [1:0]  rmp, msk;
    logic        cv, cm, ca, cf, pc, adrv, als, men, aen, pin, flt, ainf = 1'b0;
    logic [2:0]  pcnt = 3'h4;
    int          err_count = 0, tests_run = 0, n;
    vrdvfp_row_t rows[4] = '{'{1, 0, 1, 12'h003, 22, 12'h000}, '{0, 1, 0, 12'h002, 42, 12'h003},
                             '{1, 1, 1, 12'h005, 12, 12'h004}, '{1, 0, 0, 12'h004, 2, 12'h005}};
    always #2.5 clk = ~clk;
    vrdvfp_vid_master u_master (.i_clk(clk), .i_send(snd), .i_main(sm), .i_aux(sa), .i_fast(sf), .i_target(tgt),
        .i_ps_send(pss), .i_ps(ps), .o_cmd_valid(cv), .o_cmd_main(cm), .o_cmd_aux(ca), .o_fast(cf),
        .o_target(ct), .o_ps_cmd(pc), .o_ps(pso));
    vrdvfp_top #(.MASK_DELAY_CYCLES(MD), .MAIN_PHASES(4)) DUT (.i_clk(clk), .i_sys_rst(rst), .i_enable(en),
        .i_cmd_valid(cv), .i_cmd_main(cm), .i_cmd_aux(ca), .i_cmd_target(ct), .i_voltage_set_fast_cmd(cf),
        .i_power_state_cmd(pc), .i_power_state(pso), .i_phase_count(pcnt), .i_main_output_sense(msen),
        .i_aux_output_sense(12'h000), .i_total_current_monitor(total_current_monitor), .i_main_info_over(info),
        .i_aux_info_over(ainf), .o_main_ref(mref), .o_aux_ref(aref), .o_main_phase_drive_outputs(drv),
        .o_main_low_side_switch(ls), .o_aux_phase_drive_outputs(adrv), .o_aux_low_side_switch(als),
        .o_main_driver_enable(men), .o_aux_driver_enable(aen), .o_fault_indication_pin(pin),
        .o_fault_latched(flt), .o_ramping(rmp), .o_protect_masked(msk), .o_oc_level(oc));
    task automatic tick(int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(string name, logic [11:0] exp, logic [11:0] seen);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic cmd(logic m, logic a, logic f, logic [11:0] t);
        {sm, sa, sf, tgt, snd} = {m, a, f, t, 1'b1};
        tick(1);
        snd = 1'b0;
        tick(1);
    endtask
    task automatic wait_ref(logic m, logic [11:0] t);
        n = 0;
        while ((m ? mref : aref) !== t) begin
            if (n == 20000) begin
                err_count++;
                end_sim();
            end
            tick(1);
            n++;
        end
    endtask
    task automatic pstate(logic [7:0] code);
        {ps, pss} = {code, 1'b1};
        tick(1);
        pss = 1'b0;
        tick(4);
    endtask
    // enable low is the only way out of a latched fault
    task automatic en_cycle();
        en = 1'b0;
        tick(4);
        en = 1'b1;
        tick(3);
        chk("restart", 12'h000, {mref[11:1], flt});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1;
        chk("reset oc", 12'h60E, oc);
        rst = 1'b0;
        tick(3);
        chk("phases up", 12'h00F, {8'h00, drv});
        foreach (rows[i]) begin
            cmd(rows[i].m, rows[i].a, rows[i].f, rows[i].t);
            wait_ref(rows[i].m, rows[i].t);
            chk("ramp cycles", rows[i].cyc[11:0], n[11:0]);
            chk("other ref", rows[i].oth, rows[i].m ? aref : mref);
            chk("masked", 12'h001, {11'h0, |msk});
            tick(MD + 30);
            chk("mask open", 12'h000, {10'h0, msk});
        end
        $display("test ramps finished");
        {info, ainf} = {4'h3, 1'b1};
        tick(3);
        chk("low side", 12'h13C, {3'h0, als, ls, drv});
        {info, ainf} = 5'h00;
        tick(3);
        chk("drive back", 12'h00F, {3'h0, als, ls, drv});
        pstate(8'h01);
        chk("reduced oc", 12'h320, oc);
        chk("phase count", 12'h002, 12'($countones(drv)));
        pcnt = 3'h3;
        tick(2);
        chk("reduced oc n3", 12'h41A, oc);
        pcnt = 3'h4;
        pstate(8'h00);
        chk("full oc", 12'h60E, oc);
        $display("test phase limits finished");
        cmd(1, 0, 1, 12'h028);
        tick(2);
        msen = 12'hFFF;
        tick(100);
        cmd(1, 0, 0, 12'h00C);
        wait_ref(1, 12'h00C);
        msen = 12'h00C;
        tick(MD + 30);
        chk("masked ramp", 12'h000, {11'h0, flt});
        cmd(1, 0, 1, 12'h1FE);
        tick(2);
        msen = 12'h1FE;
        wait_ref(1, 12'h1FE);
        tick(MD + 30);
        msen = 12'h2AC;
        tick(10);
        chk("ov below", 12'h000, {11'h0, flt});
        msen = 12'h2AD;
        tick(4);
        chk("ov outputs", 12'h00A, {8'h0, pin, aen, men, adrv | als});
        cmd(0, 1, 1, 12'h064);
        wait_ref(1, 12'h0FA);
        chk("aux held", 12'h005, aref);
        msen = 12'h000;
        tick(4);
        chk("main hiz", 12'h000, {4'h0, drv, ls});
        en_cycle();
        $display("test overvoltage finished");
        cmd(1, 0, 1, 12'h1F6);
        tick(2);
        msen = 12'h1F6;
        wait_ref(1, 12'h1F6);
        tick(MD + 30);
        msen = 12'h003;
        tick(10);
        chk("uv above", 12'h000, {11'h0, flt});
        msen = 12'h002;
        tick(4);
        chk("uv shutdown", 12'h008, {8'h0, flt, pin, men, aen});
        en_cycle();
        cmd(1, 0, 1, 12'h014);
        tick(2);
        msen = 12'h014;
        total_current_monitor = 12'h60D;
        tick(20);
        chk("oc below", 12'h000, {11'h0, flt});
        total_current_monitor = 12'h60E;
        tick(4);
        chk("oc shutdown", 12'h800, {flt, pin, men, aen, drv, ls});
        total_current_monitor = 12'h000;
        en_cycle();
        $display("test latches finished");
        end_sim();
    end
endmodule // vrdvfp_test
`default_nettype wire
